// *** design/ufc_line_ctrl.sv ***
// uart line control: hw/sw flow control, rs-485 driver enable, multidrop matching, ahb-lite registers
//
// Chosen here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
// Operation
// - mode 001 with pins 010 uses DTR/DSR
// - pause character stops transmitter after current character
// - resume character restarts paused transmitter
// - rs-485 mode raises driver enable before start
// - zero delay drops enable after last stop
// - delay holds enable 1 to 15 bits
// - pin function bit 3 sets enable polarity
// - modes 3,4 match unicast and multicast addresses
// - match needs ninth bit set and equal
// - matching address enables receiver for data
// - non-matching address disables the receiver
// - mode 3 transmitter always enabled
// - mode 4 transmits only while matched
// - half duplex ignores receive while sending
// - ready output follows receive fifo room
// - peer ready input suspends or restarts transmitter
module ufc_line_ctrl (
	input wire logic mclk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic tx_valid,
	input wire ufc_pkg::ufc_char_s tx_char,
	output logic tx_ready,
	output logic rx_valid,
	output ufc_pkg::ufc_char_s rx_char,
	input wire logic rx_fifo_room,
	input wire logic rxd,
	input wire logic cts_n,
	input wire logic dsr_n,
	output logic txd,
	output logic rts_n,
	output logic dtr_n,
	output logic driver_enable_pin
);
	import ufc_pkg::*;
	ufc_cfg_s cfg_q;
	ufc_tx_e state_q, state_d;
	logic [2:0] pin_in, sync1_q, sync2_q, sync3_q, filt_q;
	logic rxd_f, cts_f, dsr_f;
	logic [DIV_W-1:0] baud_q;
	logic bit_tick;
	logic [FRAME_BITS_9-1:0] sh_q;
	logic [3:0] bit_q, nbits;
	logic [TURN_W-1:0] tail_q;
	logic paused_q, match_q;
	logic hw_mode, sw_mode, md_mode, rs485, peer_busy, allow, load, last, nine_bit, blank;
	logic rxf_valid;
	ufc_char_s rxf_char;
	logic ap_we_q;
	logic [ADDR_W-1:0] ap_addr_q;
	logic ap_take;
	logic [31:0] rd_d;
	logic [3:0] status;

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	assign pin_in = {dsr_n, cts_n, rxd};
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			// filtered level moves only when the second and third stages agree
			always_ff @(posedge mclk or posedge rst) begin
				if (rst) begin
					sync1_q[gi] <= 1'b1;
					sync2_q[gi] <= 1'b1;
					sync3_q[gi] <= 1'b1;
					filt_q[gi] <= 1'b1;
				end else begin
					sync1_q[gi] <= pin_in[gi];
					sync2_q[gi] <= sync1_q[gi];
					sync3_q[gi] <= sync2_q[gi];
					if (sync2_q[gi] == sync3_q[gi])
						filt_q[gi] <= sync3_q[gi];
				end
			end
		end
	endgenerate
	assign rxd_f = filt_q[0];
	assign cts_f = filt_q[1];
	assign dsr_f = filt_q[2];

	// ------------------------------------------------------------
	// mode decode and transmit gating
	// ------------------------------------------------------------
	assign hw_mode = (cfg_q.hs_mode == HS_HW) && (cfg_q.pin_func == PF_RTS || cfg_q.pin_func == PF_DTR);
	assign sw_mode = (cfg_q.hs_mode == HS_SW);
	assign md_mode = (cfg_q.hs_mode == HS_MD_OPEN) || (cfg_q.hs_mode == HS_MD_GATED);
	assign rs485 = (cfg_q.pin_func == PF_RS485);
	assign nine_bit = md_mode;
	assign peer_busy = (cfg_q.pin_func == PF_DTR) ? dsr_f : cts_f;
	// mode 3 never gates on match, mode 4 does
	assign allow = !(sw_mode && paused_q) && !(hw_mode && peer_busy)
		&& !(cfg_q.hs_mode == HS_MD_GATED && !match_q);
	assign nbits = nine_bit ? FRAME_BITS_9 : FRAME_BITS_8;
	assign last = (bit_q == nbits - 1'b1);
	assign blank = cfg_q.half_duplex && (state_q == TX_SHIFT);

	// bit-time enable; a divisor of zero wraps to the longest bit time
	// a new divisor applies only after the count in progress runs out
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			baud_q <= '0;
		else if (baud_q == '0)
			baud_q <= cfg_q.bit_div - 1'b1;
		else
			baud_q <= baud_q - 1'b1;
	end
	assign bit_tick = (baud_q == '0);

	// ------------------------------------------------------------
	// transmit sequencer
	// ------------------------------------------------------------
	// loads happen only between characters, so a pause never cuts a frame
	always_comb begin
		load = 1'b0;
		state_d = state_q;
		if (bit_tick && tx_valid && allow) begin
			case (state_q)
				TX_IDLE: load = !rs485;
				TX_LEAD: load = 1'b1;
				TX_SHIFT: load = last;
				TX_TAIL: load = 1'b1;
				default: load = 1'b0;
			endcase
		end
		if (bit_tick) begin
			case (state_q)
				TX_IDLE: begin
					if (load)
						state_d = TX_SHIFT;
					else if (tx_valid && allow && rs485)
						state_d = TX_LEAD;
				end
				TX_LEAD: state_d = load ? TX_SHIFT : TX_IDLE;
				TX_SHIFT: begin
					if (last && !load)
						state_d = (rs485 && cfg_q.turnaround_delay != '0) ? TX_TAIL : TX_IDLE;
				end
				TX_TAIL: begin
					if (load)
						state_d = TX_SHIFT;
					else if (tail_q == cfg_q.turnaround_delay)
						state_d = TX_IDLE;
				end
				default: state_d = TX_IDLE;
			endcase
		end
	end
	assign tx_ready = load;

	// state, shift register and bit counters
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_q <= TX_IDLE;
			sh_q <= '1;
			bit_q <= '0;
			tail_q <= '0;
		end else begin
			state_q <= state_d;
			if (load) begin
				sh_q <= nine_bit ? {1'b1, tx_char.addr_bit, tx_char.data, 1'b0} : {2'b11, tx_char.data, 1'b0};
				bit_q <= '0;
			end else if (bit_tick && state_q == TX_SHIFT) begin
				sh_q <= {1'b1, sh_q[FRAME_BITS_9-1:1]};
				bit_q <= bit_q + 1'b1;
			end
			if (bit_tick && state_q == TX_SHIFT)
				tail_q <= {{(TURN_W-1){1'b0}}, 1'b1};
			else if (bit_tick && state_q == TX_TAIL)
				tail_q <= tail_q + 1'b1;
		end
	end
	assign txd = sh_q[0];

	// driver enable follows the next state so it leads the start bit and drops after the stop bit and any turnaround delay
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			driver_enable_pin <= 1'b0;
		else
			driver_enable_pin <= (rs485 && state_d != TX_IDLE) ^ cfg_q.de_low;
	end

	// ready outputs, active low, inactive outside their pin function
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rts_n <= 1'b1;
			dtr_n <= 1'b1;
		end else begin
			rts_n <= (hw_mode && cfg_q.pin_func == PF_RTS) ? !rx_fifo_room : 1'b1;
			dtr_n <= (hw_mode && cfg_q.pin_func == PF_DTR) ? !rx_fifo_room : 1'b1;
		end
	end

	// ------------------------------------------------------------
	// receive path and character matching
	// ------------------------------------------------------------
	ufc_rx_frame u_rx (
		.mclk(mclk),
		.rst(rst),
		.rxd(rxd_f),
		.bit_div(cfg_q.bit_div),
		.nine_bit(nine_bit),
		.blank(blank),
		.rx_valid(rxf_valid),
		.rx_char(rxf_char)
	);

	// pause wins when both characters are programmed equal
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			paused_q <= 1'b0;
		end else if (!sw_mode) begin
			paused_q <= 1'b0;
		end else if (rxf_valid) begin
			if (rxf_char.data == cfg_q.pause_char)
				paused_q <= 1'b1;
			else if (rxf_char.data == cfg_q.resume_char)
				paused_q <= 1'b0;
		end
	end

	// address bytes steer the receiver; data bytes leave it unchanged
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			match_q <= 1'b0;
		else if (!md_mode)
			match_q <= 1'b0;
		else if (rxf_valid && rxf_char.addr_bit)
			match_q <= (rxf_char.data == cfg_q.resume_char) || (rxf_char.data == cfg_q.pause_char);
	end

	// address bytes are consumed here and never reach the fifo
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rx_valid <= 1'b0;
			rx_char <= '0;
		end else begin
			rx_valid <= rxf_valid && !(md_mode && (rxf_char.addr_bit || !match_q));
			if (rxf_valid)
				rx_char <= rxf_char;
		end
	end

	// ------------------------------------------------------------
	// ahb-lite register slave, zero wait states
	// ------------------------------------------------------------
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign ap_take = hready && hsel && htrans[HTRANS_ACT_BIT] && (hsize == HSIZE_WORD);
	assign status = {driver_enable_pin ^ cfg_q.de_low, match_q, paused_q, state_q != TX_IDLE};

	always_comb begin
		rd_d = '0;
		case (haddr[ADDR_W-1:0])
			ADDR_FLOW: rd_d[FLOW_HD_BIT:0] = {cfg_q.half_duplex, cfg_q.hs_mode};
			ADDR_PINF: rd_d[PINF_POL_BIT:0] = {cfg_q.de_low, cfg_q.pin_func};
			ADDR_RESUME: rd_d[CHAR_W-1:0] = cfg_q.resume_char;
			ADDR_PAUSE: rd_d[CHAR_W-1:0] = cfg_q.pause_char;
			ADDR_TURN: rd_d[TURN_W-1:0] = cfg_q.turnaround_delay;
			ADDR_DIV: rd_d[DIV_W-1:0] = cfg_q.bit_div;
			ADDR_STAT: rd_d[ST_DE:0] = status;
			default: rd_d = '0;
		endcase
	end

	// address phase capture; read data is latched here so hrdata comes from a flop
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ap_we_q <= 1'b0;
			ap_addr_q <= '0;
			hrdata <= '0;
		end else if (hready) begin
			ap_we_q <= ap_take && hwrite && (haddr[31:ADDR_W] == '0);
			ap_addr_q <= haddr[ADDR_W-1:0];
			if (ap_take && !hwrite)
				hrdata <= (haddr[31:ADDR_W] == '0) ? rd_d : '0;
		end
	end

	// data phase write
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cfg_q <= '{half_duplex: 1'b0, hs_mode: HS_NONE, de_low: 1'b0, pin_func: 3'h0,
				resume_char: RESUME_RST, pause_char: PAUSE_RST, turnaround_delay: '0, bit_div: DIV_RST};
		end else if (ap_we_q) begin
			case (ap_addr_q)
				ADDR_FLOW: {cfg_q.half_duplex, cfg_q.hs_mode} <= hwdata[FLOW_HD_BIT:0];
				ADDR_PINF: {cfg_q.de_low, cfg_q.pin_func} <= hwdata[PINF_POL_BIT:0];
				ADDR_RESUME: cfg_q.resume_char <= hwdata[CHAR_W-1:0];
				ADDR_PAUSE: cfg_q.pause_char <= hwdata[CHAR_W-1:0];
				ADDR_TURN: cfg_q.turnaround_delay <= hwdata[TURN_W-1:0];
				ADDR_DIV: cfg_q.bit_div <= hwdata[DIV_W-1:0];
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_de_before_start: assert property (@(posedge mclk) disable iff (rst)
		(rs485 && state_q == TX_IDLE && state_d == TX_LEAD) |=> (driver_enable_pin != cfg_q.de_low) && txd)
		else $error("driver enable not raised ahead of start bit");
	a_de_zero_drop: assert property (@(posedge mclk) disable iff (rst)
		(rs485 && state_q == TX_SHIFT && state_d == TX_IDLE && cfg_q.turnaround_delay == '0)
		|=> driver_enable_pin == cfg_q.de_low)
		else $error("driver enable held after last stop bit");
	a_de_tail_hold: assert property (@(posedge mclk) disable iff (rst)
		(state_q == TX_TAIL) |-> (tail_q <= cfg_q.turnaround_delay) && (driver_enable_pin != cfg_q.de_low))
		else $error("turnaround delay overrun or enable dropped");
	a_de_polarity: assert property (@(posedge mclk) disable iff (rst)
		(!rs485 && $stable(cfg_q.de_low) && $stable(rs485)) |=> driver_enable_pin == $past(cfg_q.de_low))
		else $error("driver enable idle level wrong");
	a_pause_block: assert property (@(posedge mclk) disable iff (rst)
		(sw_mode && paused_q) |-> !tx_ready)
		else $error("transmit loaded while paused");
	a_resume_clear: assert property (@(posedge mclk) disable iff (rst)
		(sw_mode && rxf_valid && rxf_char.data == cfg_q.resume_char && rxf_char.data != cfg_q.pause_char
		&& $stable(cfg_q.hs_mode)) |=> !paused_q)
		else $error("resume character did not clear pause");
	a_addr_match: assert property (@(posedge mclk) disable iff (rst)
		(md_mode && rxf_valid && rxf_char.addr_bit && (rxf_char.data == cfg_q.resume_char
		|| rxf_char.data == cfg_q.pause_char) && $stable(cfg_q.hs_mode)) |=> match_q && !rx_valid)
		else $error("address match missed or address byte delivered");
	a_addr_miss: assert property (@(posedge mclk) disable iff (rst)
		(md_mode && !match_q) |=> !rx_valid)
		else $error("data delivered while receiver disabled");
	a_gated_tx: assert property (@(posedge mclk) disable iff (rst)
		(cfg_q.hs_mode == HS_MD_GATED && !match_q) |-> !tx_ready)
		else $error("mode 4 transmit without address match");
	a_ready_room: assert property (@(posedge mclk) disable iff (rst)
		(hw_mode && cfg_q.pin_func == PF_RTS && !rx_fifo_room && $stable(cfg_q)) |=> rts_n)
		else $error("ready output asserted without fifo room");
	a_half_blank: assert property (@(posedge mclk) disable iff (rst)
		(cfg_q.half_duplex && state_q == TX_SHIFT) [*2] |-> !rxf_valid)
		else $error("receive accepted while transmitting in half duplex");
endmodule : ufc_line_ctrl

// *** design/ufc_pkg.sv ***
// shared constants, register map and carrier types of the uart flow and multidrop control block
package ufc_pkg;
	// ------------------------------------------------------------
	// register map (byte addresses, one word each)
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_FLOW = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_PINF = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_RESUME = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_PAUSE = 8'h0c;
	localparam logic [ADDR_W-1:0] ADDR_TURN = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_DIV = 8'h14;
	localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h18;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam int HTRANS_ACT_BIT = 1;
	// ------------------------------------------------------------
	// field layout and encodings
	// ------------------------------------------------------------
	localparam int FLOW_HD_BIT = 3;
	localparam int PINF_POL_BIT = 3;
	localparam int CHAR_W = 8;
	localparam int TURN_W = 4;
	localparam int DIV_W = 16;
	localparam logic [2:0] HS_NONE = 3'h0;
	localparam logic [2:0] HS_HW = 3'h1;
	localparam logic [2:0] HS_SW = 3'h2;
	localparam logic [2:0] HS_MD_OPEN = 3'h3;
	localparam logic [2:0] HS_MD_GATED = 3'h4;
	localparam logic [2:0] PF_RTS = 3'h1;
	localparam logic [2:0] PF_DTR = 3'h2;
	localparam logic [2:0] PF_RS485 = 3'h3;
	localparam int ST_BUSY = 0;
	localparam int ST_PAUSED = 1;
	localparam int ST_MATCH = 2;
	localparam int ST_DE = 3;
	// ------------------------------------------------------------
	// reset values and frame timing
	// ------------------------------------------------------------
	localparam logic [CHAR_W-1:0] RESUME_RST = 8'h11;
	localparam logic [CHAR_W-1:0] PAUSE_RST = 8'h13;
	localparam logic [DIV_W-1:0] DIV_RST = 16'h28b0;
	localparam logic [3:0] FRAME_BITS_8 = 4'ha;
	localparam logic [3:0] FRAME_BITS_9 = 4'hb;
	localparam logic [3:0] DATA_BITS_8 = 4'h8;
	localparam logic [3:0] DATA_BITS_9 = 4'h9;
	// ------------------------------------------------------------
	// carriers and state types
	// ------------------------------------------------------------
	typedef struct packed {
		logic half_duplex;
		logic [2:0] hs_mode;
		logic de_low;
		logic [2:0] pin_func;
		logic [CHAR_W-1:0] resume_char;
		logic [CHAR_W-1:0] pause_char;
		logic [TURN_W-1:0] turnaround_delay;
		logic [DIV_W-1:0] bit_div;
	} ufc_cfg_s;
	typedef struct packed {
		logic addr_bit;
		logic [CHAR_W-1:0] data;
	} ufc_char_s;
	typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_LEAD = 2'b01, TX_SHIFT = 2'b11, TX_TAIL = 2'b10} ufc_tx_e;
	typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b11, RX_STOP = 2'b10} ufc_rx_e;
endpackage : ufc_pkg

// *** design/ufc_rx_frame.sv ***
// receive deserializer: start detect, mid-bit sampling, 8 or 9 data bits, blanking
`timescale 1ns/1ps
module ufc_rx_frame (
	input wire logic mclk,
	input wire logic rst,
	input wire logic rxd,
	input wire logic [ufc_pkg::DIV_W-1:0] bit_div,
	input wire logic nine_bit,
	input wire logic blank,
	output logic rx_valid,
	output ufc_pkg::ufc_char_s rx_char
);
	import ufc_pkg::*;
	ufc_rx_e state_q;
	logic [DIV_W-1:0] cnt_q;
	logic [3:0] idx_q;
	logic [CHAR_W:0] sh_q;
	logic [3:0] nbits;
	logic tick;

	assign nbits = nine_bit ? DATA_BITS_9 : DATA_BITS_8;
	assign tick = (cnt_q == '0);

	// ------------------------------------------------------------
	// frame sequencer; blanking drops a frame in flight, not just its delivery
	// ------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_q <= RX_IDLE;
			cnt_q <= '0;
			idx_q <= '0;
			sh_q <= '0;
			rx_valid <= 1'b0;
			rx_char <= '0;
		end else begin
			rx_valid <= 1'b0;
			if (!tick)
				cnt_q <= cnt_q - 1'b1;
			if (blank) begin
				state_q <= RX_IDLE;
			end else begin
				case (state_q)
					RX_IDLE: begin
						if (!rxd) begin
							state_q <= RX_START;
							cnt_q <= bit_div >> 1;
						end
					end
					RX_START: begin
						if (tick) begin
							state_q <= rxd ? RX_IDLE : RX_DATA;
							cnt_q <= bit_div - 1'b1;
							idx_q <= '0;
						end
					end
					RX_DATA: begin
						if (tick) begin
							sh_q <= {rxd, sh_q[CHAR_W:1]};
							idx_q <= idx_q + 1'b1;
							cnt_q <= bit_div - 1'b1;
							if (idx_q == nbits - 1'b1)
								state_q <= RX_STOP;
						end
					end
					RX_STOP: begin
						if (tick) begin
							state_q <= RX_IDLE;
							// a framing error discards the character
							rx_valid <= rxd;
							rx_char <= nine_bit ? sh_q : {1'b0, sh_q[CHAR_W:1]};
						end
					end
					default: state_q <= RX_IDLE;
				endcase
			end
		end
	end
endmodule : ufc_rx_frame

// *** test/ufc_line_ctrl_tb.sv ***
// self-checking bench of the uart line control block with a remote node on its serial pins
`timescale 1ns/1ps
module ufc_line_ctrl_tb;
	import ufc_pkg::*;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, rd;
	logic hreadyout, hresp, tx_ready, rx_valid, txd, rts_n, dtr_n, driver_enable_pin, rxd, got, ok;
	logic tx_valid = 1'b0;
	logic rx_fifo_room = 1'b1;
	logic cts_n = 1'b0;
	logic dsr_n = 1'b0;
	logic nine = 1'b0;
	logic [7:0] lfsr = 8'h3a;
	logic [8:0] got_char;
	logic [8:0] exp_rx[$];
	logic [8:0] exp_tx[$];
	ufc_char_s tx_char = '0;
	ufc_char_s rx_char;
	logic [31:0] rst_tab[8] = '{32'h0, 32'h0, 32'h11, 32'h13, 32'h0, 32'h28b0, 32'h0, 32'h0};
	// {shown, ninth bit, data}: address bytes are never shown
	logic [9:0] md_tab[9] = '{10'h021, 10'h15a, 10'h277, 10'h1c3, 10'h044, 10'h133, 10'h25a, 10'h100, 10'h05a};
	int miscompares = 0;
	int checks = 0;
	int n, k;

	always #5 mclk = ~mclk;
	ufc_line_ctrl dut_u (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.tx_valid(tx_valid), .tx_char(tx_char), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_char(rx_char),
		.rx_fifo_room(rx_fifo_room), .rxd(rxd), .cts_n(cts_n), .dsr_n(dsr_n), .txd(txd), .rts_n(rts_n),
		.dtr_n(dtr_n), .driver_enable_pin(driver_enable_pin));
	ufc_remote_node node_u (.mclk(mclk), .txd(txd), .nine(nine), .rxd(rxd), .got(got), .got_char(got_char));

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic end_sim();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_sim
	task automatic give_up(input string what);
		miscompares++;
		$display("[FAIL] %s expected done seen timeout", what);
		end_sim();
	endtask : give_up
	function automatic logic [7:0] rnd();
		lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
		return lfsr;
	endfunction : rnd
	// slave is zero-wait, but no count is assumed: wait for hready at a rising clock
	task automatic wait_rdy();
		int i;
		for (i = 0; i < 20; i++) begin
			@(posedge mclk);
			if (hreadyout === 1'b1) break;
		end
		if (i == 20) give_up("hready");
		chk("hresp", 32'(hresp), 32'h0);
	endtask : wait_rdy
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= HSIZE_WORD;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		rd = hrdata;
	endtask : ahb
	task automatic tx_raise(input logic [8:0] ch);
		exp_tx.push_back(nine ? ch : {1'b0, ch[7:0]});
		@(posedge mclk);
		tx_valid <= 1'b1;
		tx_char <= ch;
	endtask : tx_raise
	// tx_valid stays up until taken; a refusal leaves it up for the caller to unblock
	task automatic tx_wait(input int lim, input logic must);
		int i;
		ok = 1'b0;
		for (i = 0; i < lim && !ok; i++) begin
			@(negedge mclk);
			ok = (tx_ready === 1'b1);
		end
		// return on a rising clock either way, so callers drive pins there
		@(posedge mclk);
		if (ok) begin
			tx_valid <= 1'b0;
		end else if (must) begin
			give_up("tx_ready");
		end
	endtask : tx_wait
	task automatic tx_stall(input logic [8:0] ch);
		// peer pins need four clocks through the synchroniser before they gate the sender
		repeat (4) @(posedge mclk);
		tx_raise(ch);
		tx_wait(300, 1'b0);
		chk("tx_held", 32'(ok), 32'h0);
	endtask : tx_stall
	task automatic rx_send(input logic [8:0] ch, input logic shown);
		if (shown) exp_rx.push_back({1'b0, ch[7:0]});
		node_u.send(ch);
	endtask : rx_send

	// scoreboard: oldest note against every result that appears
	always @(posedge mclk) begin
		if (rx_valid === 1'b1) begin
			chk("rx_char", 32'(rx_char), 32'(exp_rx.size() > 0 ? exp_rx.pop_front() : 9'h1ff));
		end
		if (got === 1'b1) begin
			chk("tx_char", 32'(got_char), 32'(exp_tx.size() > 0 ? exp_tx.pop_front() : 9'h1ff));
		end
	end
	// hang guard
	initial begin
		#900us;
		give_up("run");
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (20) @(posedge mclk);
		chk("rst_pins", {28'h0, txd, rts_n, dtr_n, driver_enable_pin}, 32'he);
		rst <= 1'b0;
		repeat (4) @(posedge mclk);
		for (n = 0; n < 8; n++) begin
			ahb(1'b0, 8'(4 * n), 32'h0);
			chk("reg_rst", rd, rst_tab[n]);
		end
		ahb(1'b1, 8'h1c, 32'hffffffff);
		ahb(1'b0, 8'h1c, 32'h0);
		chk("unmapped", rd, 32'h0);
		ahb(1'b1, ADDR_DIV, 32'h10);
		ahb(1'b0, ADDR_DIV, 32'h0);
		chk("div", rd, 32'h10);
		// the bit-time counter runs out its reset-length count before the new divisor applies
		repeat (int'(DIV_RST)) @(posedge mclk);
		$display("test registers done");
		for (n = 0; n < 3; n++) begin
			tx_raise({1'b0, rnd()});
			tx_wait(600, 1'b1);
			rx_send({1'b0, rnd()}, 1'b1);
		end
		$display("test plain frames done");
		// pin function 1 uses rts/cts, 2 uses dtr/dsr
		for (n = 1; n < 3; n++) begin
			ahb(1'b1, ADDR_FLOW, {29'h0, HS_HW});
			ahb(1'b1, ADDR_PINF, 32'(n));
			rx_fifo_room <= 1'b0;
			repeat (4) @(posedge mclk);
			chk("ready_off", 32'((n == 1) ? rts_n : dtr_n), 32'h1);
			rx_fifo_room <= 1'b1;
			repeat (4) @(posedge mclk);
			chk("ready_on", 32'((n == 1) ? rts_n : dtr_n), 32'h0);
			cts_n <= (n == 1);
			dsr_n <= (n == 2);
			tx_stall({1'b0, rnd()});
			cts_n <= 1'b0;
			dsr_n <= 1'b0;
			tx_wait(600, 1'b1);
		end
		$display("test hardware flow done");
		ahb(1'b1, ADDR_PINF, 32'h0);
		ahb(1'b1, ADDR_FLOW, {29'h0, HS_SW});
		tx_raise({1'b0, rnd()});
		tx_wait(600, 1'b1);
		// pause lands while the second character is on the wire: it must finish
		fork
			begin
				repeat (40) @(posedge mclk);
				rx_send(9'h013, 1'b1);
			end
			begin
				tx_raise({1'b0, rnd()});
				tx_wait(600, 1'b1);
			end
		join
		tx_stall({1'b0, rnd()});
		ahb(1'b0, ADDR_STAT, 32'h0);
		chk("paused", 32'(rd[ST_PAUSED]), 32'h1);
		fork
			rx_send(9'h011, 1'b1);
			tx_wait(900, 1'b1);
		join
		// let the last frame leave the line before the pin function changes
		repeat (200) @(posedge mclk);
		$display("test software flow done");
		ahb(1'b1, ADDR_FLOW, 32'h0);
		for (n = 0; n < 2; n++) begin
			ahb(1'b1, ADDR_TURN, 32'(3 * n));
			ahb(1'b1, ADDR_PINF, {28'h0, n[0], PF_RS485});
			repeat (2) @(posedge mclk);
			chk("de_idle", 32'(driver_enable_pin), 32'(n[0]));
			tx_raise({1'b0, rnd()});
			fork
				tx_wait(600, 1'b1);
				begin
					for (k = 0; k < 600 && txd !== 1'b0; k++) @(posedge mclk);
					chk("de_lead", 32'(driver_enable_pin), 32'(!n[0]));
					for (k = 0; k < 900 && driver_enable_pin !== n[0]; k++) @(posedge mclk);
					chk("de_hold", 32'(k >= 159 + 48 * n && k <= 162 + 48 * n), 32'h1);
				end
			join
		end
		$display("test driver enable done");
		ahb(1'b1, ADDR_PINF, 32'h0);
		ahb(1'b1, ADDR_RESUME, 32'h5a);
		ahb(1'b1, ADDR_PAUSE, 32'h33);
		ahb(1'b1, ADDR_FLOW, {29'h0, HS_MD_OPEN});
		nine <= 1'b1;
		for (n = 0; n < 9; n++) rx_send(md_tab[n][8:0], md_tab[n][9]);
		tx_raise(9'h1a5);
		tx_wait(600, 1'b1);
		ahb(1'b1, ADDR_FLOW, {29'h0, HS_MD_GATED});
		tx_stall({1'b0, rnd()});
		fork
			rx_send(9'h133, 1'b0);
			tx_wait(900, 1'b1);
		join
		// a 9-bit frame cut by a mode change would lose its stop bit
		repeat (200) @(posedge mclk);
		$display("test multidrop done");
		nine <= 1'b0;
		ahb(1'b1, ADDR_FLOW, 32'(1 << FLOW_HD_BIT));
		tx_raise({1'b0, rnd()});
		// a frame arriving during the send is ignored; its tail is kept at mark
		fork
			tx_wait(600, 1'b1);
			begin
				repeat (30) @(posedge mclk);
				rx_send({1'b0, 8'h80 | rnd()}, 1'b0);
			end
		join
		repeat (100) @(posedge mclk);
		rx_send({1'b0, rnd()}, 1'b1);
		repeat (200) @(posedge mclk);
		chk("pending", 32'(exp_rx.size() + exp_tx.size()), 32'h0);
		$display("test half duplex done");
		end_sim();
	end
endmodule : ufc_line_ctrl_tb

// *** test/ufc_remote_node.sv ***
// remote uart node: drives frames onto the block's receive pin and decodes frames from its transmit pin
`timescale 1ns/1ps
module ufc_remote_node #(
	parameter int BIT_CYC = 16
) (
	input wire logic mclk,
	input wire logic txd,
	input wire logic nine,
	output logic rxd,
	output logic got,
	output logic [8:0] got_char
);
	int rx_i;
	logic [8:0] rx_c;
	// the line rests at mark between frames, as a real node leaves it
	initial begin
		rxd = 1'b1;
		got = 1'b0;
		got_char = 9'h000;
	end
	// one frame, lsb first; the ninth bit only travels on 9-bit links
	task automatic send(input logic [8:0] ch);
		int i;
		@(posedge mclk);
		rxd <= 1'b0;
		repeat (BIT_CYC) @(posedge mclk);
		for (i = 0; i < (nine ? 9 : 8); i++) begin
			rxd <= ch[i];
			repeat (BIT_CYC) @(posedge mclk);
		end
		rxd <= 1'b1;
		repeat (BIT_CYC) @(posedge mclk);
	endtask : send
	// mid-bit sampler; a frame with a low stop bit is dropped, so got never lies
	always begin
		@(negedge txd);
		repeat (BIT_CYC / 2) @(posedge mclk);
		rx_c = 9'h000;
		for (rx_i = 0; rx_i < (nine ? 9 : 8); rx_i++) begin
			repeat (BIT_CYC) @(posedge mclk);
			rx_c[rx_i] = txd;
		end
		repeat (BIT_CYC) @(posedge mclk);
		if (txd === 1'b1) begin
			got_char <= rx_c;
			got <= 1'b1;
			@(posedge mclk);
			got <= 1'b0;
		end
	end
endmodule : ufc_remote_node
